// file: rtl/rcid_consts.svh
/*
 Register offsets, field positions, reset values and timing counts
 of the instruction decode block. Assumes a byte-addressed
 AXI4-Lite register space with one 32-bit word per register.
*/
`ifndef RCID_CONSTS_SVH
`define RCID_CONSTS_SVH
// Summary of operation
// - Literal load copies the 8-bit immediate into W; flags untouched.
// - Store copies W into the addressed file register; flags untouched.
// - The all-zero word does nothing for one instruction cycle.
// - Configuration load copies W into the option register, no flags.
// - Interrupt return pops PC in two cycles, keeps W, clears irq-off.
// - Literal return pops PC, loads immediate into W, two cycles.
// - Plain return pops PC in two cycles; W and irq-off unchanged.
// - Rotate left through carry: carry into bit 0, bit 7 out.
// - Rotate right through carry: carry into bit 7, bit 0 out.
// - Sleep halts core; touches irq flags; reset, watchdog or irq wake.
// - Subtract file minus W; updates carry, digit carry and zero.
// - Swap exchanges nibbles of the file register; flags unchanged.
// - Port direction load copies W into direction of port A, B or C.
// - XOR literal into W; only zero flag changes.
// - XOR W with file register to destination; only zero changes.
// - File operand is five low bits; immediate is eight bits.
// - One instruction cycle spans four oscillator clocks.
// - Destination bit 0 writes W; bit 1 writes the file register.
// - Instructions changing the program counter take two cycles.

// -----------------------------------------------------------
// Register offsets
// -----------------------------------------------------------
`define RCID_OFF_INSTR 8'h00
`define RCID_OFF_STATUS 8'h04
`define RCID_OFF_WREG 8'h08
`define RCID_OFF_OPTION 8'h0C
`define RCID_OFF_PORTDIR 8'h10
`define RCID_OFF_FSEL 8'h14
`define RCID_OFF_FDATA 8'h18
`define RCID_OFF_PC 8'h1C
`define RCID_OFF_STACK 8'h20

// -----------------------------------------------------------
// Fields, reset values, timing
// -----------------------------------------------------------
`define RCID_STAT_BUSY 5
`define RCID_STAT_SLEEP 6
`define RCID_DBIT 5
`define RCID_RST_OPTION 8'hFF
`define RCID_RST_PORTDIR 8'hFF
`define RCID_CLKS_PER_CYC 4
`define RCID_RESP_OKAY 2'b00
`define RCID_RESP_SLVERR 2'b10
`endif

// file: rtl/rcid_pkg.sv
/*
 Types of the instruction decode block. Assumes the constants
 header is included by the modules that need offsets.
*/
package rcid_pkg;

    // -----------------------------------------------------------
    // Sequencer states and decoded operations
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        RCID_ST_IDLE = 3'b001,
        RCID_ST_EXEC = 3'b010,
        RCID_ST_SLEEP = 3'b100
    } rcid_state_e;

    typedef enum logic [3:0] {
        RCID_OP_NOP, RCID_OP_LDLIT, RCID_OP_STORE, RCID_OP_OPTION,
        RCID_OP_RETURN_FROM_IRQ, RCID_OP_RETURN_WITH_LITERAL, RCID_OP_RETURN, RCID_OP_RLF,
        RCID_OP_RRF, RCID_OP_SLEEP, RCID_OP_SUB, RCID_OP_SWAP,
        RCID_OP_LOAD_PORT_DIRECTION, RCID_OP_XOR_LITERAL_ACC, RCID_OP_XOR_ACC_FILE
    } rcid_op_e;

    // Flag bits 4:0 of the status register
    typedef struct packed {
        logic wdt_irq;
        logic irq_dis;
        logic z;
        logic dc;
        logic c;
    } rcid_flags_s;

endpackage : rcid_pkg

// file: rtl/rcid_exec_if.sv
/*
 Interface between the sequencer and the decoder datapath.
 Assumes the core drives operands and the decoder is combinational.
*/
`timescale 1ns/100ps
interface rcid_exec_if;
    logic [11:0] instr;
    logic [7:0] wval;
    logic [7:0] fval;
    logic cin;
    logic [4:0] faddr;
    logic [7:0] res;
    logic c_out;
    logic dc_out;
    logic z_out;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic to_w;
    logic to_f;
    logic two_cycle;
    logic pop;
    logic is_return_from_irq;
    logic is_sleep;
    logic is_option;
    logic [2:0] load_port_direction_sel;
    modport exec(input instr, wval, fval, cin, output faddr, res, c_out,
        dc_out, z_out, upd_c, upd_dc, upd_z, to_w, to_f, two_cycle, pop,
        is_return_from_irq, is_sleep, is_option, load_port_direction_sel);
    modport core(output instr, wval, fval, cin, input faddr, res, c_out,
        dc_out, z_out, upd_c, upd_dc, upd_z, to_w, to_f, two_cycle, pop,
        is_return_from_irq, is_sleep, is_option, load_port_direction_sel);
endinterface : rcid_exec_if

// file: rtl/rcid_exec.sv
/*
 Combinational decoder and datapath for one instruction word.
 Assumes the core holds the word and operands stable while executing.
*/
`timescale 1ns/100ps
`include "rcid_consts.svh"
module rcid_exec
    import rcid_pkg::*;
(
    // Decode and datapath port
    rcid_exec_if.exec dx
);
    function automatic rcid_op_e dec(input logic [11:0] i);
        casez (i)
            12'b1100_????_????: dec = RCID_OP_LDLIT;
            12'b0000_001?_????: dec = RCID_OP_STORE;
            12'b0000_0000_0010: dec = RCID_OP_OPTION;
            12'b0000_0000_1001: dec = RCID_OP_RETURN_FROM_IRQ;
            12'b1000_????_????: dec = RCID_OP_RETURN_WITH_LITERAL;
            12'b0000_0000_1000: dec = RCID_OP_RETURN;
            12'b0011_01??_????: dec = RCID_OP_RLF;
            12'b0011_00??_????: dec = RCID_OP_RRF;
            12'b0000_0000_0011: dec = RCID_OP_SLEEP;
            12'b0000_10??_????: dec = RCID_OP_SUB;
            12'b0011_10??_????: dec = RCID_OP_SWAP;
            12'b0000_0000_0101: dec = RCID_OP_LOAD_PORT_DIRECTION;
            12'b0000_0000_011?: dec = RCID_OP_LOAD_PORT_DIRECTION;
            12'b1111_????_????: dec = RCID_OP_XOR_LITERAL_ACC;
            12'b0001_10??_????: dec = RCID_OP_XOR_ACC_FILE;
            default: dec = RCID_OP_NOP;
        endcase
    endfunction : dec

    rcid_op_e op;
    wire [7:0] f = dx.fval;
    wire [7:0] w = dx.wval;
    wire [7:0] lit = dx.instr[7:0];
    wire dbit = dx.instr[`RCID_DBIT];
    wire [8:0] diff = {1'b0, f} - {1'b0, w};
    wire [4:0] ndiff = {1'b0, f[3:0]} - {1'b0, w[3:0]};
    wire byte_op = op inside {RCID_OP_RLF, RCID_OP_RRF, RCID_OP_SUB,
        RCID_OP_SWAP, RCID_OP_XOR_ACC_FILE};

    assign op = dec(dx.instr);
    assign dx.faddr = dx.instr[4:0];
    assign dx.res = (op == RCID_OP_RLF) ? {f[6:0], dx.cin} :
        (op == RCID_OP_RRF) ? {dx.cin, f[7:1]} :
        (op == RCID_OP_SUB) ? diff[7:0] :
        (op == RCID_OP_SWAP) ? {f[3:0], f[7:4]} :
        (op == RCID_OP_XOR_LITERAL_ACC) ? (w ^ lit) :
        (op == RCID_OP_XOR_ACC_FILE) ? (w ^ f) :
        (op == RCID_OP_STORE) ? w : lit;
    assign dx.c_out = (op == RCID_OP_RLF) ? f[7] :
        (op == RCID_OP_RRF) ? f[0] : ~diff[8];
    assign dx.dc_out = ~ndiff[4];
    assign dx.z_out = (dx.res == 8'h00);
    assign dx.upd_c = op inside {RCID_OP_RLF, RCID_OP_RRF, RCID_OP_SUB};
    assign dx.upd_dc = (op == RCID_OP_SUB);
    assign dx.upd_z = op inside {RCID_OP_SUB, RCID_OP_XOR_LITERAL_ACC,
        RCID_OP_XOR_ACC_FILE};
    assign dx.to_f = (byte_op & dbit) | (op == RCID_OP_STORE);
    assign dx.to_w = (byte_op & ~dbit) | (op inside {RCID_OP_LDLIT,
        RCID_OP_RETURN_WITH_LITERAL, RCID_OP_XOR_LITERAL_ACC});
    assign dx.pop = op inside {RCID_OP_RETURN_FROM_IRQ, RCID_OP_RETURN_WITH_LITERAL,
        RCID_OP_RETURN};
    assign dx.two_cycle = dx.pop;
    assign dx.is_return_from_irq = (op == RCID_OP_RETURN_FROM_IRQ);
    assign dx.is_sleep = (op == RCID_OP_SLEEP);
    assign dx.is_option = (op == RCID_OP_OPTION);
    assign dx.load_port_direction_sel = {3{op == RCID_OP_LOAD_PORT_DIRECTION}} & {
        dx.instr[2:0] == 3'h7, dx.instr[2:0] == 3'h6,
        dx.instr[2:0] == 3'h5};
endmodule : rcid_exec

// file: rtl/rcid_regfile.sv
/*
 File register array: one write port, two asynchronous read ports.
 Assumes the caller never writes from two sources in one cycle.
*/
`timescale 1ns/100ps
module rcid_regfile #(
    parameter int DEPTH = 32,
    parameter int AW = 5
)
(
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read ports
    input wire logic [AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [7:0] rdata_b
);
    // Contents are not reset, as in a real data memory
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule : rcid_regfile

// file: rtl/rcid_core.sv
/*
 Instruction sequencer with AXI4-Lite register access. Software
 writes one instruction word, the core executes it and commits.
 Assumes one clock (the instruction oscillator) and synchronous
 wake inputs.
*/
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "rcid_consts.svh"
module rcid_core
    import rcid_pkg::*;
#(
    parameter int PC_W = 11,
    parameter int STACK_D = 8
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Wake sources
    input wire logic wake_irq,
    input wire logic wdt_event,
    // Core state outputs
    output logic osc_run,
    output logic instr_done,
    output logic [7:0] option_out,
    output logic [7:0] port_dir_a,
    output logic [7:0] port_dir_b,
    output logic [7:0] port_dir_c
);
    localparam int SP_W = $clog2(STACK_D);
    localparam logic [2:0] LAST1 = 3'(`RCID_CLKS_PER_CYC - 1);
    localparam logic [2:0] LAST2 = 3'(2 * `RCID_CLKS_PER_CYC - 1);

    // -----------------------------------------------------------
    // Architectural state
    // -----------------------------------------------------------
    rcid_exec_if dx();
    rcid_state_e st_reg;
    rcid_state_e st_next;
    rcid_flags_s fl_reg;
    rcid_flags_s fl_next;
    logic [2:0] tick_reg;
    logic [2:0] tick_next;
    logic [11:0] instr_reg;
    logic [11:0] instr_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic [7:0] opt_next;
    logic [7:0] dira_next;
    logic [7:0] dirb_next;
    logic [7:0] dirc_next;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [SP_W-1:0] sp_reg;
    logic [SP_W-1:0] sp_next;
    logic [PC_W-1:0] stack_mem [STACK_D];
    logic [4:0] fsel_reg;
    logic [4:0] fsel_next;
    logic [7:0] bus_fval;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic push;
    logic [7:0] wa_reg;
    logic [31:0] wd_reg;
    logic [3:0] ws_reg;
    logic [31:0] old_val;
    logic [31:0] rd_val;

    // -----------------------------------------------------------
    // Register map helpers
    // -----------------------------------------------------------
    function automatic logic known(input logic [7:0] a);
        known = a inside {`RCID_OFF_INSTR, `RCID_OFF_STATUS,
            `RCID_OFF_WREG, `RCID_OFF_OPTION, `RCID_OFF_PORTDIR,
            `RCID_OFF_FSEL, `RCID_OFF_FDATA, `RCID_OFF_PC,
            `RCID_OFF_STACK};
    endfunction : known

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        rd_mux = 32'h0000_0000;
        case (a)
            `RCID_OFF_INSTR: rd_mux[11:0] = instr_reg;
            `RCID_OFF_STATUS:
            begin
                rd_mux[4:0] = fl_reg;
                rd_mux[`RCID_STAT_BUSY] = (st_reg == RCID_ST_EXEC);
                rd_mux[`RCID_STAT_SLEEP] = (st_reg == RCID_ST_SLEEP);
            end
            `RCID_OFF_WREG: rd_mux[7:0] = w_reg;
            `RCID_OFF_OPTION: rd_mux[7:0] = option_out;
            `RCID_OFF_PORTDIR:
                rd_mux[23:0] = {port_dir_c, port_dir_b, port_dir_a};
            `RCID_OFF_FSEL: rd_mux[4:0] = fsel_reg;
            `RCID_OFF_FDATA: rd_mux[7:0] = bus_fval;
            `RCID_OFF_PC: rd_mux[PC_W-1:0] = pc_reg;
            `RCID_OFF_STACK: rd_mux[SP_W-1:0] = sp_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction : rd_mux

    // -----------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------
    wire idle = (st_reg == RCID_ST_IDLE);
    wire is_exec = (st_reg == RCID_ST_EXEC);
    wire ar_fire = arvalid & arready;
    // Both halves held and no answer pending
    wire wr_go = ~awready & ~wready & ~bvalid;
    // Writes land only between instructions, keeping commits atomic
    wire wr_ok = wr_go & idle & known(wa_reg);
    wire [31:0] wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}},
        {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    wire [31:0] wr_val = (old_val & ~wmask) | (wd_reg & wmask);
    wire last = tick_reg == (dx.two_cycle ? LAST2 : LAST1);
    wire commit = is_exec & last;
    wire [SP_W-1:0] sp_dec = sp_reg - 1'b1;

    assign dx.instr = instr_reg;
    assign dx.wval = w_reg;
    assign dx.cin = fl_reg.c;

    always_comb
    begin
        old_val = rd_mux(wa_reg);
        rd_val = rd_mux(araddr);
    end

    // -----------------------------------------------------------
    // Datapath and file registers
    // -----------------------------------------------------------
    rcid_exec u_exec (
        .dx (dx.exec)
    );

    rcid_regfile #(.DEPTH(32), .AW(5)) u_rf (
        .clk (aclk),
        .we (rf_we),
        .waddr (rf_waddr),
        .wdata (rf_wdata),
        .raddr_a (dx.faddr),
        .rdata_a (dx.fval),
        .raddr_b (fsel_reg),
        .rdata_b (bus_fval)
    );

    // -----------------------------------------------------------
    // Sequencer next state
    // -----------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        tick_next = tick_reg;
        instr_next = instr_reg;
        w_next = w_reg;
        fl_next = fl_reg;
        opt_next = option_out;
        dira_next = port_dir_a;
        dirb_next = port_dir_b;
        dirc_next = port_dir_c;
        pc_next = pc_reg;
        sp_next = sp_reg;
        fsel_next = fsel_reg;
        push = 1'b0;
        rf_we = 1'b0;
        rf_waddr = fsel_reg;
        rf_wdata = wr_val[7:0];
        unique case (st_reg)
            RCID_ST_IDLE:
            begin
                if (wr_ok)
                begin
                    case (wa_reg)
                        `RCID_OFF_INSTR:
                        begin
                            instr_next = wr_val[11:0];
                            tick_next = 3'd0;
                            st_next = RCID_ST_EXEC;
                        end
                        `RCID_OFF_STATUS: fl_next = wr_val[4:0];
                        `RCID_OFF_WREG: w_next = wr_val[7:0];
                        `RCID_OFF_FSEL: fsel_next = wr_val[4:0];
                        `RCID_OFF_FDATA: rf_we = 1'b1;
                        `RCID_OFF_PC: pc_next = wr_val[PC_W-1:0];
                        `RCID_OFF_STACK:
                        begin
                            push = 1'b1;
                            sp_next = sp_reg + 1'b1;
                        end
                        default: push = 1'b0;
                    endcase
                end
            end
            RCID_ST_EXEC:
            begin
                tick_next = tick_reg + 3'd1;
                if (last)
                begin
                    tick_next = 3'd0;
                    st_next = RCID_ST_IDLE;
                    pc_next = pc_reg + 1'b1;
                    if (dx.to_w)
                        w_next = dx.res;
                    if (dx.to_f)
                    begin
                        rf_we = 1'b1;
                        rf_waddr = dx.faddr;
                        rf_wdata = dx.res;
                    end
                    if (dx.upd_c)
                        fl_next.c = dx.c_out;
                    if (dx.upd_dc)
                        fl_next.dc = dx.dc_out;
                    if (dx.upd_z)
                        fl_next.z = dx.z_out;
                    if (dx.is_option)
                        opt_next = w_reg;
                    if (dx.load_port_direction_sel[0])
                        dira_next = w_reg;
                    if (dx.load_port_direction_sel[1])
                        dirb_next = w_reg;
                    if (dx.load_port_direction_sel[2])
                        dirc_next = w_reg;
                    if (dx.pop)
                    begin
                        pc_next = stack_mem[sp_dec];
                        sp_next = sp_dec;
                    end
                    if (dx.is_return_from_irq)
                        fl_next.irq_dis = 1'b0;
                    if (dx.is_sleep)
                    begin
                        st_next = RCID_ST_SLEEP;
                        fl_next.irq_dis = 1'b0;
                        fl_next.wdt_irq = 1'b0;
                    end
                end
            end
            RCID_ST_SLEEP:
            begin
                if (wake_irq | wdt_event)
                    st_next = RCID_ST_IDLE;
            end
        endcase
        // A watchdog event beats any clear in the same cycle
        if (wdt_event)
            fl_next.wdt_irq = 1'b1;
    end

    // -----------------------------------------------------------
    // State registers
    // -----------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= RCID_ST_IDLE;
            fl_reg <= '0;
            tick_reg <= 3'd0;
            instr_reg <= 12'h000;
            w_reg <= 8'h00;
            option_out <= `RCID_RST_OPTION;
            port_dir_a <= `RCID_RST_PORTDIR;
            port_dir_b <= `RCID_RST_PORTDIR;
            port_dir_c <= `RCID_RST_PORTDIR;
            pc_reg <= '0;
            sp_reg <= '0;
            fsel_reg <= 5'h00;
            osc_run <= 1'b1;
            instr_done <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            fl_reg <= fl_next;
            tick_reg <= tick_next;
            instr_reg <= instr_next;
            w_reg <= w_next;
            option_out <= opt_next;
            port_dir_a <= dira_next;
            port_dir_b <= dirb_next;
            port_dir_c <= dirc_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            fsel_reg <= fsel_next;
            osc_run <= (st_next != RCID_ST_SLEEP);
            instr_done <= commit;
        end
    end

    // Stack overflow wraps silently, oldest entry is overwritten
    always_ff @(posedge aclk)
    begin
        if (push)
            stack_mem[sp_reg] <= wr_val[PC_W-1:0];
    end

    // -----------------------------------------------------------
    // AXI4-Lite slave
    // -----------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RCID_RESP_OKAY;
            wa_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
        end
        else
        begin
            if (awvalid & awready)
            begin
                awready <= 1'b0;
                wa_reg <= awaddr;
            end
            if (wvalid & wready)
            begin
                wready <= 1'b0;
                wd_reg <= wdata;
                ws_reg <= wstrb;
            end
            if (wr_go)
            begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RCID_RESP_OKAY : `RCID_RESP_SLVERR;
            end
            else if (bvalid & bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RCID_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= known(araddr) ? `RCID_RESP_OKAY : `RCID_RESP_SLVERR;
        end
        else if (rvalid & rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule : rcid_core

// file: sim/rcid_core_sva.sv
/* Port checker for rcid_core.
 Assumes it is bound to every rcid_core instance. */
`timescale 1ns/100ps
module rcid_core_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Core state
    input wire logic wake_irq,
    input wire logic wdt_event,
    input wire logic osc_run,
    input wire logic instr_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd; arvalid && arready |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read late");
    property p_rhold; rvalid && !rready |=> rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_arblk; rvalid |-> !arready; endproperty
    a_arblk: assert property (p_arblk) else $error("second read");
    // Only a write whose two halves are taken together has a fixed answer
    property p_wr;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write late");
    property p_bhold; bvalid && !bready |=> bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_awblk; bvalid |-> !awready; endproperty
    a_awblk: assert property (p_awblk) else $error("second write");
    property p_done; instr_done |=> !instr_done; endproperty
    a_done: assert property (p_done) else $error("done held");
    // Wake takes effect at most two edges later
    property p_wake;
        !osc_run && (wake_irq || wdt_event) |-> ##[1:2] osc_run;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_stay;
        !osc_run && !wake_irq && !wdt_event && !$past(wake_irq)
            && !$past(wdt_event) |=> !osc_run;
    endproperty
    a_stay: assert property (p_stay) else $error("woke alone");
    c_done: cover property (instr_done);
    c_wake: cover property (!osc_run ##1 osc_run);
    c_rd: cover property (rvalid && rready);
endmodule : rcid_core_sva
bind rcid_core rcid_core_sva chk (.*);

// file: sim/tb_top.sv
/* Bench for rcid_core over its register bus.
 Assumes the register map and timing of the core. */
`timescale 1ns/100ps
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, wake_irq = 0, wdt_event = 0;
    logic awready, wready, bvalid, arready, rvalid, osc_run, instr_done;
    logic [7:0] awaddr = 0, araddr = 0, option_out;
    logic [7:0] port_dir_a, port_dir_b, port_dir_c;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rs;
    int miscompares = 0, check_count = 0, cyc = 0, n0, n1;
    rcid_core dut (.*);
    initial forever #12.5 aclk = ~aclk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Generous ceiling: the tests need a few hundred cycles
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH at %0t: %h vs %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        while (!bvalid);
        bready <= 0;
        rs = bresp;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        while (!rvalid);
        rready <= 0;
        rd = rdata;
        rs = rresp;
    endtask : rdr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask : rc
    task automatic run(input logic [11:0] op, output int n);
        wr(8'h00, {20'h0, op});
        n = 0;
        while (!instr_done)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : run
    task automatic t_lit;
        wr(8'h04, 32'h1);
        chk(rs, 32'h0);
        run(12'hC5A, n0);
        rc(8'h08, 32'h5A);
        chk(rs, 32'h0);
        rc(8'h04, 32'h1);
        run(12'hF5A, n0);
        rc(8'h08, 32'h0);
        rc(8'h04, 32'h5);
        run(12'hF01, n0);
        rc(8'h04, 32'h1);
        run(12'h000, n0);
        rc(8'h08, 32'h1);
        $display("end lit");
    endtask : t_lit
    task automatic t_file;
        wr(8'h14, 32'h3);
        wr(8'h18, 32'h10);
        wr(8'h08, 32'h1);
        wr(8'h04, 32'h0);
        run(12'h083, n0);
        rc(8'h08, 32'hF);
        rc(8'h04, 32'h1);
        rc(8'h18, 32'h10);
        run(12'h023, n0);
        rc(8'h18, 32'hF);
        run(12'h1A3, n0);
        rc(8'h18, 32'h0);
        rc(8'h04, 32'h5);
        wr(8'h18, 32'h81);
        wr(8'h04, 32'h0);
        run(12'h363, n0);
        rc(8'h18, 32'h2);
        rc(8'h04, 32'h1);
        run(12'h303, n0);
        rc(8'h08, 32'h81);
        rc(8'h04, 32'h0);
        wr(8'h04, 32'h1);
        run(12'h3A3, n0);
        rc(8'h18, 32'h20);
        rc(8'h04, 32'h1);
        $display("end file");
    endtask : t_file
    task automatic t_port;
        wr(8'h08, 32'h3C);
        run(12'h002, n0);
        run(12'h005, n0);
        wr(8'h08, 32'h5A);
        run(12'h006, n0);
        run(12'h007, n0);
        chk(option_out, 32'h3C);
        rc(8'h10, 32'h5A5A3C);
        chk({port_dir_c, port_dir_b, port_dir_a}, 32'h5A5A3C);
        $display("end port");
    endtask : t_port
    task automatic t_ret;
        wr(8'h20, 32'h123);
        run(12'h000, n0);
        chk(n0, 32'h4);
        run(12'h877, n1);
        rc(8'h08, 32'h77);
        rc(8'h1C, 32'h123);
        chk(n1 - n0, 32'h4);
        wr(8'h20, 32'h45);
        wr(8'h04, 32'h8);
        run(12'h008, n0);
        rc(8'h1C, 32'h45);
        rc(8'h04, 32'h8);
        wr(8'h20, 32'hAA);
        run(12'h009, n0);
        rc(8'h1C, 32'hAA);
        rc(8'h04, 32'h0);
        rc(8'h08, 32'h77);
        $display("end ret");
    endtask : t_ret
    task automatic t_sleep;
        for (int i = 0; i < 2; i++)
        begin
            run(12'h003, n0);
            @(posedge aclk);
            chk(osc_run, 32'h0);
            rc(8'h04, 32'h40);
            wr(8'h08, 32'h1);
            chk(rs, 32'h2);
            wake_irq <= (i == 0);
            wdt_event <= (i == 1);
            @(posedge aclk);
            wake_irq <= 0;
            wdt_event <= 0;
            repeat (2) @(posedge aclk);
            chk(osc_run, 32'h1);
            rc(8'h04, {27'h0, i == 1, 4'h0});
        end
        rdr(8'h40);
        chk(rs, 32'h2);
        $display("end sleep");
    endtask : t_sleep
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_lit;
        t_file;
        t_port;
        t_ret;
        t_sleep;
        give_verdict;
    end
endmodule : tb_top
